// *** include/srs_pkg.sv ***
// Package for the squitter rate scheduler: timing constants, kinds and carriers.
package srs_pkg;
    // Clock rate and derived cycle counts.
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HALF_SEC_MS = 500;
    localparam int unsigned FIVE_SEC_MS = 5000;
    localparam int unsigned TEN_SEC_MS = 10000;
    localparam int unsigned LOCKOUT_MS = 60000;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    // Millisecond tick width and period counter width.
    localparam int unsigned MS_W = 16;
    localparam int unsigned PER_W = 16;
    // Random spread: interval = nominal - half span + lfsr bits (in ms), mean equals nominal.
    localparam int unsigned JIT_W = 8;
    localparam logic [PER_W-1:0] JIT_HALF = 16'h0080;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam int unsigned N_KIND = 5;
    // Squitter kinds, also the index of each scheduler slot.
    typedef enum logic [2:0] {
        SRS_AIR_POS,
        SRS_AIR_VEL,
        SRS_IDENT,
        SRS_SURF_POS,
        SRS_EVENT,
        SRS_NONE
    } srs_kind_t;
    // Ground command carrier, taken from decoded addressed interrogations.
    typedef struct packed {
        logic valid;       // One-cycle strobe of a decoded command.
        logic lockout;     // Surface squitter lockout request.
        logic hold_high;   // Forbid the low surface rate.
        logic fmt_surface; // Ground selects surface format.
        logic fmt_air;     // Ground selects airborne format.
    } srs_cmd_t;
endpackage

// *** core/srs_slot.sv ***
// One squitter slot: random-period timer with a pending flag that survives busy transmitter.
`timescale 1ns/1ps
module srs_slot (
    input wire logic clk_i,                       // Clock.
    input wire logic rst_i,                       // Synchronous reset.
    input wire logic ms_tick_i,                   // One-millisecond tick.
    input wire logic enable_i,                    // Slot is scheduled in current mode.
    input wire logic [srs_pkg::PER_W-1:0] nom_i,  // Nominal period in ms.
    input wire logic [srs_pkg::JIT_W-1:0] rnd_i,  // Random spread bits.
    input wire logic grant_i,                     // Pending squitter was sent.
    output logic pend_o                           // Squitter waiting for the transmitter.
);
    import srs_pkg::*;
    logic [PER_W-1:0] cnt_q;
    logic due;
    // A new due waits while the last one is still owed, so two squitters never merge into one.
    assign due = enable_i && ms_tick_i && (cnt_q == '0) && !pend_o;
    // Period counter reloads a fresh random interval; it rests at zero while a squitter is still owed.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (!enable_i) begin
            cnt_q <= '0;
        end else if (ms_tick_i) begin
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 16'h0001;
            end else if (!pend_o) begin
                cnt_q <= nom_i - JIT_HALF + {{(PER_W-JIT_W){1'b0}}, rnd_i};
            end
        end
    end
    // Pending is cleared by a grant or when the slot is disabled, so a busy transmitter postpones rather than drops; set wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_o <= 1'b0;
        end else if (due) begin
            pend_o <= 1'b1;
        end else if (grant_i || !enable_i) begin
            pend_o <= 1'b0;
        end
    end
endmodule

// *** core/srs_sched.sv ***
// Extended squitter rate scheduler: picks which squitter to send and when.
`timescale 1ns/1ps
module srs_sched
    import srs_pkg::*;
#(
    parameter int unsigned MS_CYC = srs_pkg::MS_CYCLES  // Cycles per millisecond.
) (
    input wire logic clk_i,              // Clock, 40 MHz.
    input wire logic rst_i,              // Synchronous reset, active high.
    input wire logic gnd_sensor_fit_i,   // On-ground sensor fitted.
    input wire logic gnd_sensor_i,       // Sensor reports on ground.
    input wire logic [1:0] trs_i,        // Rate subfield, bit 0 set means moving.
    input wire srs_pkg::srs_cmd_t cmd_i, // Decoded ground command.
    input wire logic event_load_i,       // Event message loaded, one-cycle pulse.
    input wire logic xmtr_busy_i,        // Transmitter busy with reply or squitter.
    input wire logic acq_due_i,          // Acquisition squitter due, held until started.
    output logic send_o,                 // Start transmission, one-cycle pulse.
    output srs_pkg::srs_kind_t kind_o,   // Kind of squitter started.
    output logic acq_send_o,             // Acquisition squitter start pulse.
    output logic surface_o,              // Surface format in use.
    output logic high_rate_o,            // High rate from motion in either format, or from hold on the surface.
    output logic lockout_o,              // Surface lockout active.
    output logic [1:0] trs_rd_o          // Rate subfield readback for ground.
);
    logic [MS_W-1:0] ms_cnt_q;
    logic ms_tick_q;
    logic [15:0] lfsr_q;
    logic [PER_W-1:0] lock_q, fmt_q, evgap_q;
    logic fmt_cmd_q, fmt_surf_q, hold_q, ev_pend_q;
    logic surf, high;
    logic [N_KIND-1:0] en, pend, grant;
    logic [PER_W-1:0] nom [N_KIND];
    logic [2:0] sel;
    logic free;

    // Millisecond tick divider.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_q <= '0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= (ms_cnt_q == MS_W'(MS_CYC - 1));
            ms_cnt_q <= (ms_cnt_q == MS_W'(MS_CYC - 1)) ? '0 : ms_cnt_q + 16'h0001;
        end
    end

    // Free-running random source shared by the periodic slots.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? LFSR_TAPS : 16'h0000);
        end
    end

    // Ground format command with its own timeout; it overrides the sensor while live.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fmt_cmd_q <= 1'b0;
            fmt_surf_q <= 1'b0;
            fmt_q <= '0;
        end else if (cmd_i.valid && (cmd_i.fmt_surface || cmd_i.fmt_air)) begin
            fmt_cmd_q <= 1'b1;
            fmt_surf_q <= cmd_i.fmt_surface;
            fmt_q <= PER_W'(LOCKOUT_MS);
        end else if (ms_tick_q && fmt_cmd_q) begin
            fmt_q <= fmt_q - 16'h0001;
            fmt_cmd_q <= (fmt_q != 16'h0001);
        end
    end
    // Sensor decides format when fitted and no command is live; no sensor means airborne unless commanded.
    assign surf = fmt_cmd_q ? fmt_surf_q : (gnd_sensor_fit_i && gnd_sensor_i);

    // Hold-high command, latched until the aircraft leaves the surface.
    always_ff @(posedge clk_i) begin
        if (rst_i || !surf) begin
            hold_q <= 1'b0;
        end else if (cmd_i.valid && cmd_i.hold_high) begin
            hold_q <= 1'b1;
        end
    end
    assign high = trs_i[0] || hold_q;

    // Surface lockout timer; ignored in airborne format.
    always_ff @(posedge clk_i) begin
        if (rst_i || !surf) begin
            lock_q <= '0;
        end else if (cmd_i.valid && cmd_i.lockout) begin
            lock_q <= PER_W'(LOCKOUT_MS);
        end else if (ms_tick_q && lock_q != '0) begin
            lock_q <= lock_q - 16'h0001;
        end
    end

    // Slot enables and nominal periods per mode.
    always_comb begin
        en[SRS_AIR_POS] = !surf;
        en[SRS_AIR_VEL] = !surf;
        en[SRS_IDENT] = 1'b1;
        en[SRS_SURF_POS] = surf && (lock_q == '0);
        en[SRS_EVENT] = 1'b0;
        nom[SRS_AIR_POS] = PER_W'(HALF_SEC_MS);
        nom[SRS_AIR_VEL] = PER_W'(HALF_SEC_MS);
        nom[SRS_IDENT] = (surf && !high) ? PER_W'(TEN_SEC_MS) : PER_W'(FIVE_SEC_MS);
        nom[SRS_SURF_POS] = high ? PER_W'(HALF_SEC_MS) : PER_W'(FIVE_SEC_MS);
        nom[SRS_EVENT] = '0;
    end

    // Periodic slots, each with a different slice of the random word.
    genvar g;
    generate
        for (g = 0; g < N_KIND - 1; g++) begin : g_slot
            srs_slot u_slot (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ms_tick_i(ms_tick_q),
                .enable_i(en[g]),
                .nom_i(nom[g]),
                .rnd_i(lfsr_q[(g*2)+:JIT_W]),
                .grant_i(grant[g]),
                .pend_o(pend[g])
            );
        end
    endgenerate

    // Event message: one send per load, spaced at least half a second apart.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_pend_q <= 1'b0;
        end else if (event_load_i) begin
            ev_pend_q <= 1'b1;
        end else if (grant[SRS_EVENT]) begin
            ev_pend_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evgap_q <= '0;
        end else if (grant[SRS_EVENT]) begin
            evgap_q <= PER_W'(HALF_SEC_MS);
        end else if (ms_tick_q && evgap_q != '0) begin
            evgap_q <= evgap_q - 16'h0001;
        end
    end
    assign pend[SRS_EVENT] = ev_pend_q && (evgap_q == '0);

    // Fixed-priority pick among pending squitters when the transmitter is free.
    assign free = !xmtr_busy_i && !send_o && !acq_send_o;
    always_comb begin
        sel = 3'(SRS_NONE);
        for (int i = N_KIND - 1; i >= 0; i--) begin
            if (pend[i]) begin
                sel = 3'(i);
            end
        end
    end
    generate
        for (g = 0; g < N_KIND; g++) begin : g_grant
            assign grant[g] = free && !acq_due_i && (sel == 3'(g));
        end
    endgenerate

    // Output registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            send_o <= 1'b0;
            kind_o <= SRS_NONE;
            acq_send_o <= 1'b0;
            surface_o <= 1'b0;
            high_rate_o <= 1'b0;
            lockout_o <= 1'b0;
            trs_rd_o <= 2'h0;
        end else begin
            send_o <= |grant;
            kind_o <= (|grant) ? srs_kind_t'(sel) : SRS_NONE;
            acq_send_o <= acq_due_i && free;
            surface_o <= surf;
            high_rate_o <= high;
            lockout_o <= surf && (lock_q != '0);
            trs_rd_o <= trs_i;
        end
    end

    // Checks.
    lock_air_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !surface_o |-> !lockout_o) else $error("Lockout active in airborne format.");
    lock_surf_a: assert property (@(posedge clk_i) disable iff (rst_i)
        send_o && kind_o == SRS_SURF_POS |-> !$past(lockout_o)) else $error("Surface position sent in lockout.");
    ev_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        grant[SRS_EVENT] |=> !ev_pend_q || $past(event_load_i)) else $error("Event sent twice.");
    ev_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        grant[SRS_EVENT] |=> evgap_q == PER_W'(HALF_SEC_MS)) else $error("Event spacing not armed.");
    pend_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pend[SRS_IDENT] && xmtr_busy_i && en[SRS_IDENT] |=> pend[SRS_IDENT]) else $error("Pending squitter lost.");
    free_send_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|pend) && free && !acq_due_i |=> send_o) else $error("Free transmitter not used.");
    air_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !surf |-> nom[SRS_AIR_POS] == 16'h01F4) else $error("Airborne period wrong.");
    surf_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        surf && hold_q |-> nom[SRS_SURF_POS] == 16'h01F4 && nom[SRS_IDENT] == 16'h1388) else $error("Hold not high.");
    acq_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acq_due_i && free |=> acq_send_o) else $error("Acquisition squitter dropped.");
endmodule

// *** sim/srs_xmtr_model.sv ***
// Transmitter model that stands behind the scheduler and reports when it is on air.
`timescale 1ns/1ps
module srs_xmtr_model #(
    parameter int TX_CYC = 20  // Cycles the transmitter stays busy after the start cycle.
) (
    input wire logic clk_i,    // Clock.
    input wire logic start_i,  // Squitter start from the scheduler.
    input wire logic reply_i,  // Addressed reply in progress.
    output logic busy_o        // Transmitter busy.
);
    int left = 0;
    // A start loads the air-time counter, so back-to-back grants are refused like the real transmitter.
    always @(posedge clk_i) begin
        if (start_i) begin
            left <= TX_CYC;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    // The start cycle already counts as busy.
    assign busy_o = reply_i || start_i || (left > 0);
endmodule

// *** sim/srs_sched_test.sv ***
// Self-checking bench for the squitter rate scheduler.
`timescale 1ns/1ps
module srs_sched_test;
    import srs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fit = 1'b0;
    logic gnd = 1'b0;
    logic ev = 1'b0;
    logic acq = 1'b0;
    logic reply = 1'b0;
    logic [1:0] trs = 2'h0;
    srs_cmd_t cmd = '0;
    logic busy, send, acq_send, surf, high, lock;
    srs_kind_t kind;
    logic [1:0] trs_rd;
    int fail_count = 0;
    int cmp_count = 0;
    int n[6];
    int n_acq, last_ev, min_gap, w, s0, s1;
    int cyc = 0;
    always #12.5 clk_i = ~clk_i;
    // One millisecond per cycle keeps the long periods inside the run budget.
    srs_sched #(.MS_CYC(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .gnd_sensor_fit_i(fit), .gnd_sensor_i(gnd),
        .trs_i(trs), .cmd_i(cmd), .event_load_i(ev), .xmtr_busy_i(busy), .acq_due_i(acq), .send_o(send),
        .kind_o(kind), .acq_send_o(acq_send), .surface_o(surf), .high_rate_o(high), .lockout_o(lock),
        .trs_rd_o(trs_rd));
    srs_xmtr_model u_xmtr (.clk_i(clk_i), .start_i(send || acq_send), .reply_i(reply), .busy_o(busy));
    // Counts starts per kind since reset and the closest spacing of event squitters.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rst_i) begin
            foreach (n[k]) n[k] <= 0;
            n_acq <= 0;
            last_ev <= -100000;
            min_gap <= 100000;
        end else begin
            if (send === 1'b1 && kind < SRS_NONE) n[kind] <= n[kind] + 1;
            if (acq_send === 1'b1) n_acq <= n_acq + 1;
            if (send === 1'b1 && kind == SRS_EVENT) begin
                last_ev <= cyc;
                if (cyc - last_ev < min_gap) min_gap <= cyc - last_ev;
            end
        end
    end
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic rng(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // Reset with the given sensor and rate inputs; outputs must sit idle while held.
    task automatic restart(input logic f, input logic g, input logic [1:0] t);
        fit <= f;
        gnd <= g;
        trs <= t;
        rst_i <= 1'b1;
        tick(10);
        chk("reset outputs", 16'h0005, {send, acq_send, surf, high, lock, trs_rd, kind});
        rst_i <= 1'b0;
        tick(3);
    endtask
    task automatic command(input logic lk, input logic hh, input logic fs, input logic fa);
        cmd <= srs_cmd_t'{1'b1, lk, hh, fs, fa};
        tick(1);
        cmd <= '0;
        tick(3);
    endtask
    task automatic load_event();
        ev <= 1'b1;
        tick(1);
        ev <= 1'b0;
    endtask
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Windows of 10000 ms hold 15..27 half-second squitters and 2..3 five-second ones.
    initial begin
        restart(1'b0, 1'b0, 2'h1);
        tick(10000);
        rng("air position", 15, 27, n[SRS_AIR_POS]);
        rng("air velocity", 15, 27, n[SRS_AIR_VEL]);
        rng("air ident", 2, 3, n[SRS_IDENT]);
        rng("surface position in air", 0, 0, n[SRS_SURF_POS]);
        // A long reply holds everything off; the backlog must follow at once, nothing lost.
        reply <= 1'b1;
        tick(1000);
        s0 = n[SRS_AIR_POS];
        s1 = n[SRS_AIR_VEL];
        chk("start while replying", 16'h0, send);
        reply <= 1'b0;
        w = 0;
        while (send !== 1'b1 && w < 10) begin
            tick(1);
            w++;
        end
        rng("first start after reply", 1, 3, w);
        chk("first kind after reply", 16'(SRS_AIR_POS), kind);
        tick(200);
        rng("postponed positions", 1, 2, n[SRS_AIR_POS] - s0);
        rng("postponed velocities", 1, 2, n[SRS_AIR_VEL] - s1);
        // Event loads: each sent once, a second load waits out the half second.
        restart(1'b0, 1'b0, 2'h0);
        tick(600);
        load_event();
        tick(100);
        rng("first event", 1, 1, n[SRS_EVENT]);
        load_event();
        tick(300);
        rng("event held back", 1, 1, n[SRS_EVENT]);
        tick(1300);
        rng("event count", 2, 2, n[SRS_EVENT]);
        rng("event spacing", 500, 100000, min_gap);
        // Surface, moving.
        restart(1'b1, 1'b1, 2'h1);
        tick(10000);
        rng("surface position moving", 15, 27, n[SRS_SURF_POS]);
        rng("surface ident moving", 2, 3, n[SRS_IDENT]);
        rng("air position on surface", 0, 0, n[SRS_AIR_POS]);
        chk("surface high status", 16'h6, {surf, high, lock});
        chk("rate readback", 16'h1, trs_rd);
        // Surface, stationary, then motion and the ground hold.
        restart(1'b1, 1'b1, 2'h2);
        tick(10000);
        rng("surface position still", 2, 3, n[SRS_SURF_POS]);
        rng("surface ident still", 1, 2, n[SRS_IDENT]);
        chk("low rate", 16'h0, high);
        chk("rate readback still", 16'h2, trs_rd);
        trs <= 2'h1;
        tick(3);
        chk("motion high rate", 16'h1, high);
        trs <= 2'h0;
        tick(3);
        chk("back to low rate", 16'h0, high);
        command(1'b0, 1'b1, 1'b0, 1'b0);
        chk("hold high rate", 16'h1, high);
        // Lockout is ignored in airborne format and honoured after surface format is commanded.
        restart(1'b1, 1'b0, 2'h1);
        command(1'b1, 1'b0, 1'b0, 1'b0);
        chk("lockout in air", 16'h0, lock);
        command(1'b0, 1'b0, 1'b1, 1'b0);
        chk("surface by command", 16'h1, surf);
        command(1'b1, 1'b0, 1'b0, 1'b0);
        chk("lockout on surface", 16'h1, lock);
        s0 = n[SRS_SURF_POS];
        repeat (6) begin
            acq <= 1'b1;
            w = 0;
            while (acq_send !== 1'b1 && w < 40) begin
                tick(1);
                w++;
            end
            acq <= 1'b0;
            tick(480);
        end
        rng("acquisition in lockout", 6, 6, n_acq);
        rng("surface position in lockout", 0, 0, n[SRS_SURF_POS] - s0);
        chk("lockout still on", 16'h1, lock);
        // Airborne command beats a sensor that says on ground, and lockout falls with the surface format.
        gnd <= 1'b1;
        command(1'b0, 1'b0, 1'b0, 1'b1);
        chk("air by command", 16'h0, {surf, lock});
        summarize();
    end
    // The sequence needs about 36500 cycles, so 100000 cycles means a hang.
    initial begin
        #(25 * 100000);
        fail_count++;
        summarize();
    end
endmodule
